// ### verilog/msw_ctrl.sv
/*
 APB-controlled driver for a latching multiport RF switch.
 Assumes the switch indicator sense lines arrive asynchronously on pins.
*/
`timescale 1ns/1ps
`include "msw_cfg.svh"
module msw_ctrl
    import msw_pkg::*;
#(
    parameter int PULSE_CYC = `MSW_PULSE_CYC
)
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [`MSW_NPATH-1:0] sense_in,
    output logic      [`MSW_NPATH-1:0] drive_out,
    output logic                       open_all_out
);
    msw_state_type state;
    logic [31:0]           ctrl;
    logic [`MSW_NPATH-1:0] sense_meta;
    logic [`MSW_NPATH-1:0] sense;
    logic [`MSW_NPATH-1:0] want;
    logic [`MSW_NPATH-1:0] old_sel;
    logic [`MSW_NPATH-1:0] next_drive;
    logic                  next_open;
    logic                  busy;
    logic                  done;
    logic                  err;
    logic                  tload;
    logic [31:0]           tcount;
    logic                  tdone;
    logic                  ovl;
    logic                  go;
    logic                  wr;
    logic                  is_open;
    logic                  mbb;
    logic                  hold;
    logic                  ttl;
    logic [2:0]            path;

    assign wr      = psel && penable && pwrite;
    assign go      = wr && paddr == `MSW_REG_CTRL
                     && pwdata[`MSW_CTRL_GO_BIT] && !busy;
    assign is_open = ctrl[`MSW_CTRL_OPEN_BIT];
    assign mbb     = ctrl[`MSW_CTRL_MBB_BIT];
    assign hold    = ctrl[`MSW_CTRL_HOLD_BIT];
    assign ttl     = ctrl[`MSW_CTRL_TTL_BIT];
    assign path    = ctrl[`MSW_CTRL_PATH_LSB +: 3];

    // Indicator lines are position, not command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_meta <= '0;
            sense      <= '0;
        end else begin
            sense_meta <= sense_in;
            sense      <= sense_meta;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `MSW_NPATH; g++) begin : g_want
            assign want[g] = !is_open && path == 3'(g);
        end
    endgenerate

    msw_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tload),
        .count   (tcount),
        .done    (tdone)
    );

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MSW_CTRL_RESET;
        end else if (wr && paddr == `MSW_REG_CTRL && !busy) begin
            ctrl <= {1'b0, pwdata[30:0]};
        end
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= MSW_IDLE;
            next_drive <= '0;
            next_open <= 1'b0;
            old_sel   <= '0;
            ovl       <= 1'b0;
            tload     <= 1'b0;
            tcount    <= 32'h0000_0000;
            busy      <= 1'b0;
            done      <= 1'b0;
            err       <= 1'b0;
        end else begin
            tload <= 1'b0;
            unique case (state)
                MSW_IDLE: begin
                    if (go) begin
                        busy    <= 1'b1;
                        done    <= 1'b0;
                        err     <= 1'b0;
                        old_sel <= next_drive;
                        if (pwdata[`MSW_CTRL_MBB_BIT]
                            && !pwdata[`MSW_CTRL_OPEN_BIT]) begin
                            state <= MSW_OVLAP;
                        end else begin
                            next_drive <= '0;
                            next_open  <= 1'b0;
                            tcount     <= `MSW_GAP_CYC;
                            tload      <= 1'b1;
                            state      <= MSW_BREAK;
                        end
                    end
                end
                MSW_BREAK: begin
                    if (tdone) begin
                        if (is_open && ctrl[`MSW_CTRL_NOOA_BIT]) begin
                            err   <= 1'b1;
                            busy  <= 1'b0;
                            state <= MSW_IDLE;
                        end else begin
                            next_drive <= want;
                            next_open  <= is_open;
                            tcount     <= PULSE_CYC;
                            tload      <= 1'b1;
                            state      <= MSW_DRIVE;
                        end
                    end
                end
                MSW_OVLAP: begin
                    next_drive <= old_sel | want;
                    ovl        <= 1'b1;
                    tcount     <= PULSE_CYC;
                    tload      <= 1'b1;
                    state      <= MSW_DRIVE;
                end
                MSW_DRIVE: begin
                    if (tdone && ovl) begin
                        // Release only the old path, new keeps driving
                        next_drive <= want;
                        ovl        <= 1'b0;
                        tcount     <= PULSE_CYC;
                        tload      <= 1'b1;
                    end else if (tdone) begin
                        // Pulse width at least 15 ms
                        next_drive <= hold ? want : '0;
                        next_open  <= 1'b0;
                        state      <= MSW_CHECK;
                    end
                end
                MSW_CHECK: begin
                    // Completion read back from indicators
                    done  <= 1'b1;
                    err   <= is_open ? (sense != '0) : (sense != want);
                    busy  <= 1'b0;
                    state <= hold ? MSW_HOLD : MSW_IDLE;
                end
                MSW_HOLD: begin
                    if (go) begin
                        state <= MSW_IDLE;
                        busy  <= 1'b0;
                    end
                end
                default: state <= MSW_IDLE;
            endcase
            if (state == MSW_HOLD && go) begin
                busy    <= 1'b1;
                done    <= 1'b0;
                err     <= 1'b0;
                old_sel <= next_drive;
                if (pwdata[`MSW_CTRL_MBB_BIT]
                    && !pwdata[`MSW_CTRL_OPEN_BIT]) begin
                    state <= MSW_OVLAP;
                end else begin
                    next_drive <= '0;
                    tcount     <= `MSW_GAP_CYC;
                    tload      <= 1'b1;
                    state      <= MSW_BREAK;
                end
            end
        end
    end

    // Pin polarity per variant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle level of standard variant, no path asserted
            drive_out    <= '1;
            open_all_out <= 1'b1;
        end else begin
            drive_out    <= ttl ? next_drive : ~next_drive;
            open_all_out <= ttl ? next_open : !next_open;
        end
    end

    // Read data and handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    `MSW_REG_CTRL:   prdata <= ctrl;
                    `MSW_REG_STATUS: prdata <= {29'h0, err, done, busy};
                    `MSW_REG_SENSE:  prdata <= {26'h0, sense};
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // msw_ctrl

// ### verilog/msw_cfg.svh
/*
 Timing counts and register map constants for the switch path controller.
 Assumes a 100 MHz pclk and 32-bit APB register access.
*/
`ifndef MSW_CFG_SVH
`define MSW_CFG_SVH

`define MSW_NPATH          6
`define MSW_CLK_MHZ        100
`define MSW_PULSE_MS       15
`define MSW_PULSE_CYC      (`MSW_PULSE_MS * 1000 * `MSW_CLK_MHZ)
`define MSW_GAP_CYC        2

`define MSW_REG_CTRL       12'h000
`define MSW_REG_STATUS     12'h004
`define MSW_REG_SENSE      12'h008

`define MSW_CTRL_PATH_LSB  0
`define MSW_CTRL_OPEN_BIT  4
`define MSW_CTRL_MBB_BIT   5
`define MSW_CTRL_HOLD_BIT  6
`define MSW_CTRL_TTL_BIT   7
`define MSW_CTRL_NOOA_BIT  8
`define MSW_CTRL_GO_BIT    31
`define MSW_CTRL_RESET     32'h0000_0000

`define MSW_ST_BUSY_BIT    0
`define MSW_ST_DONE_BIT    1
`define MSW_ST_ERR_BIT     2

`endif

// ### verilog/msw_pkg.sv
/*
 Types for the switch path controller.
 Assumes msw_cfg.svh is included by the users.
*/
package msw_pkg;
    typedef enum logic [5:0] {
        MSW_IDLE  = 6'b000001,
        MSW_BREAK = 6'b000010,
        MSW_DRIVE = 6'b000100,
        MSW_OVLAP = 6'b001000,
        MSW_CHECK = 6'b010000,
        MSW_HOLD  = 6'b100000
    } msw_state_type;
endpackage

// ### verilog/msw_timer.sv
/*
 Down counter giving one-cycle done pulse after a loaded cycle count.
 Assumes a single pclk domain and asynchronous active low reset.
*/
`timescale 1ns/1ps
module msw_timer
    import msw_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [31:0] count,
    output logic             done
);
    logic [31:0] remain;
    logic        run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= 32'h0000_0000;
            run    <= 1'b0;
        end else if (load) begin
            remain <= count;
            run    <= 1'b1;
        end else if (run && remain > 32'h0000_0001) begin
            remain <= remain - 32'h0000_0001;
        end else begin
            run <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= run && !load && remain <= 32'h0000_0001;
        end
    end
endmodule // msw_timer

// ### tb/msw_ctrl_sva.sv
/*
 Bus and drive-pattern checks for the switch path controller.
 Assumes it is bound to msw_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`include "msw_cfg.svh"
module msw_ctrl_chk (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [`MSW_NPATH-1:0] sense_in,
    input wire logic [`MSW_NPATH-1:0] drive_out,
    input wire logic                  open_all_out
);
    logic [`MSW_NPATH-1:0] sense_q;
    logic [2:0]            stab;
    logic                  acc;
    assign acc = psel && penable && pready;
    // Cycles the indicators have been steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_q <= '0;
            stab    <= 3'h0;
        end else begin
            sense_q <= sense_in;
            if (sense_in != sense_q)
                stab <= 3'h0;
            else if (stab != 3'h7)
                stab <= stab + 3'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_unmapped;
        acc && paddr > 12'h008 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
    property p_mapped;
        acc && paddr inside {12'h000, 12'h004, 12'h008} |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_go_clear;
        acc && !pwrite && paddr == 12'h000 |-> !prdata[31];
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("go reads one");
    property p_sense_reg;
        acc && !pwrite && paddr == 12'h008 && stab > 3'h3
            |-> prdata[5:0] == sense_in;
    endproperty
    a_sense_reg: assert property (p_sense_reg) else $error("sense wrong");
    property p_engaged;
        $countones(drive_out ^ {6{open_all_out}}) inside {0, 1, 2, 6};
    endproperty
    a_engaged: assert property (p_engaged) else $error("drive clash");
endmodule // msw_ctrl_chk

// ### tb/msw_switch_model.sv
/*
 Behavioural latching six-path switch with position indicators.
 Assumes drive pins sampled on pclk; LATCH below the drive pulse.
*/
`timescale 1ns/1ps
`include "msw_cfg.svh"
module msw_switch_model #(
    parameter int LATCH = 16
) (
    input  wire logic                  pclk,
    input  wire logic                  ttl,
    input  wire logic                  no_open_all,
    input  wire logic [`MSW_NPATH-1:0] drive,
    input  wire logic                  open_all,
    output logic      [`MSW_NPATH-1:0] sense
);
    logic [`MSW_NPATH:0]   req;
    logic [`MSW_NPATH:0]   req_q = '0;
    logic [`MSW_NPATH-1:0] closed = '0;
    int                    run = 0;
    assign req = ttl ? {open_all, drive} : ~{open_all, drive};
    assign sense = closed;
    always @(posedge pclk) begin
        req_q <= req;
        run <= (req == req_q) ? run + 1 : 0;
        // Latch asserted paths, open all others, then ignore drive
        if (req == req_q && run == LATCH - 2 && req != '0
            && (req[5:0] != '0 || !no_open_all))
            closed <= req[5:0];
        // Released path opens, remaining one stays
        if (req[5:0] != '0 && (req[5:0] & ~req_q[5:0]) == '0
            && req != req_q)
            closed <= closed & req[5:0];
    end
endmodule // msw_switch_model

// ### tb/testbench.sv
/*
 Self-checking bench for the switch path controller over APB.
 Assumes the switch model and checker from this folder.
*/
`timescale 1ns/1ps
`include "msw_cfg.svh"
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, er, ttl = 0, no_oa = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [5:0]  sense, drive;
    logic        open_all;
    int          fails = 0, checks_done = 0, cyc = 0;
    always #5 pclk = ~pclk;
    msw_ctrl #(.PULSE_CYC(20)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sense_in(sense), .drive_out(drive), .open_all_out(open_all));
    msw_switch_model #(.LATCH(16)) sw (.pclk, .ttl,
        .no_open_all(no_oa), .drive, .open_all, .sense);
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input logic [31:0] c, input logic e,
                       input logic [5:0] s);
        int n;
        apb(1'b1, `MSW_REG_CTRL, c | 32'h8000_0000);
        n = 0;
        do begin
            apb(1'b0, `MSW_REG_STATUS, '0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        check(rd[2:0], {e, ~e, 1'b0});
        apb(1'b0, `MSW_REG_SENSE, '0);
        check(rd[5:0], s);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MSW_REG_CTRL, '0);
        check(rd, `MSW_CTRL_RESET);
        for (int p = 0; p < 6; p++)
            run(p, 1'b0, 6'h01 << p);
        // Second command while busy is ignored
        apb(1'b1, `MSW_REG_CTRL, 32'h8000_0003);
        run(32'h5, 1'b0, 6'h08);
        ttl <= 1'b1;
        run(32'h82, 1'b0, 6'h04);
        run(32'hC1, 1'b0, 6'h02);
        check(drive, 6'h02);
        run(32'hA4, 1'b0, 6'h10);
        check(drive, 6'h00);
        run(32'h90, 1'b0, 6'h00);
        check(drive, 6'h00);
        no_oa <= 1'b1;
        run(32'h190, 1'b1, 6'h00);
        apb(1'b0, 12'h00C, '0);
        check(er, 1'b1);
        print_verdict();
    end
endmodule // testbench
bind msw_ctrl msw_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .sense_in, .drive_out,
    .open_all_out);
